/* File: hdl/cfg_header_pkg.sv */
// Constants, field layouts and carrier types for the configuration header block
package cfg_header_pkg;

  // Byte offsets of the configuration words
  localparam logic [7:0] CLASS_OFFSET   = 8'h08;
  localparam logic [7:0] TENURE_OFFSET  = 8'h0c;
  localparam logic [7:0] LAYOUT_OFFSET  = 8'h0e;
  localparam logic [7:0] WINDOW_OFFSET  = 8'h10;

  // Dword index width of a configuration access
  localparam int INDEX_WIDTH = 6;

  // Fixed field values of the class code word
  localparam logic [7:0] BASE_CATEGORY_VALUE   = 8'h0c;
  localparam logic [7:0] SUBCLASS_VALUE        = 8'h00;
  localparam logic [7:0] PROGRAMMING_MODEL     = 8'h10;

  // Fixed field values of the layout and self-test half word
  localparam logic [7:0] SELF_TEST_VALUE       = 8'h00;
  localparam logic [7:0] LAYOUT_KIND_VALUE     = 8'h00;

  // Window base field layout
  localparam int         WINDOW_LSB            = 11;
  localparam logic [31:0] WINDOW_WRITE_MASK    = 32'hfffff800;
  localparam logic [6:0] WINDOW_SIZE_CODE      = 7'h00;
  localparam logic       PREFETCH_FLAG         = 1'b0;
  localparam logic [1:0] DECODE_WIDTH_TYPE     = 2'h0;
  localparam logic       SPACE_INDICATOR       = 1'b0;

  // Values after reset of the writable fields
  localparam logic [7:0]  TENURE_LIMIT_RESET   = 8'h00;
  localparam logic [7:0]  LINE_SIZE_RESET      = 8'h00;
  localparam logic [20:0] WINDOW_BASE_RESET    = 21'h000000;

  // Initiator commands that use the line size
  localparam logic [3:0] CMD_READ_MULTIPLE     = 4'hc;
  localparam logic [3:0] CMD_READ_LINE         = 4'he;
  localparam logic [3:0] CMD_WRITE_INVALIDATE  = 4'hf;

  // One configuration access as sampled at the port
  typedef struct packed {
    logic                   write;
    logic [INDEX_WIDTH-1:0] index;
    logic [3:0]             byte_enable;
    logic [31:0]            wdata;
  } cfg_req_type;

  // Writable state of the header
  typedef struct packed {
    logic [7:0]  tenure_limit;
    logic [7:0]  line_size_setting;
    logic [20:0] window_base_pointer;
  } header_state_type;

endpackage

/* File: hdl/tenure_timer.sv */
// Bus tenure counter started at the beginning of each initiator transaction
`timescale 1ns/1ps
`default_nettype none
module tenure_timer (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // Transaction tracking
  input  wire logic       start,
  input  wire logic       busy,
  input  wire logic [7:0] limit,
  // Status
  output logic            expired
);

  typedef enum logic [2:0] {
    T_IDLE    = 3'b001,
    T_COUNT   = 3'b010,
    T_EXPIRED = 3'b100
  } tenure_state_type;

  tenure_state_type state_reg;
  tenure_state_type state_next;
  logic [7:0]       count_reg;
  logic [7:0]       count_next;

  always_comb begin
    state_next = state_reg;
    count_next = count_reg;
    if (start) begin
      count_next = 8'h00;
      state_next = (limit == 8'h00) ? T_EXPIRED : T_COUNT;
    end else begin
      unique case (state_reg)
        T_IDLE: begin
          state_next = T_IDLE;
        end
        T_COUNT: begin
          if (!busy) begin
            state_next = T_IDLE;
          end else begin
            count_next = count_reg + 8'h01;
            if (count_next == limit) begin
              state_next = T_EXPIRED;
            end
          end
        end
        T_EXPIRED: begin
          if (!busy) begin
            state_next = T_IDLE;
          end
        end
        default: begin
          state_next = T_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= T_IDLE;
      count_reg <= 8'h00;
    end else begin
      state_reg <= state_next;
      count_reg <= count_next;
    end
  end

  assign expired = (state_reg == T_EXPIRED);

endmodule
`default_nettype wire

/* File: hdl/window_match.sv */
// Address compare of a memory cycle against the register window
`timescale 1ns/1ps
`default_nettype none
module window_match (
  // Window setup
  input  wire logic        enable,
  input  wire logic [20:0] base_pointer,
  // Memory cycle
  input  wire logic        cycle,
  input  wire logic [31:0] address,
  // Result
  output logic             hit
);

  // Only the upper bits take part, so the window is 2K bytes long and aligned
  assign hit = enable && cycle
            && (address[31:cfg_header_pkg::WINDOW_LSB] == base_pointer);

endmodule
`default_nettype wire

/* File: hdl/cfg_header_regs.sv */
// Configuration header words 08h to 10h with tenure limit and window decode
`timescale 1ns/1ps
`default_nettype none
module cfg_header_regs #(
  // Value is arbitrary
  parameter logic [7:0] SILICON_REVISION = 8'h5a
) (
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        RESETN,
  // Configuration access
  input  wire logic        CFG_SEL,
  input  wire logic        CFG_WRITE,
  input  wire logic [5:0]  CFG_INDEX,
  input  wire logic [3:0]  CFG_BE,
  input  wire logic [31:0] CFG_WDATA,
  output logic [31:0]      CFG_RDATA,
  output logic             CFG_ACK,
  // Memory window
  input  wire logic        MEMORY_RESPONSE_ENABLE,
  input  wire logic        MEM_CYCLE,
  input  wire logic [31:0] MEM_ADDR,
  output logic             MEM_CLAIM,
  // Initiator side
  input  wire logic        FRAME_START,
  input  wire logic        TRANSFER_BUSY,
  input  wire logic        GNT_N,
  input  wire logic [3:0]  INIT_CMD,
  output logic             TENURE_EXPIRED,
  output logic             TERMINATE_REQ,
  output logic [7:0]       LINE_SIZE,
  output logic [7:0]       BURST_WORDS
);

  localparam int IW = cfg_header_pkg::INDEX_WIDTH;

  // Dword indices derived from the byte offsets
  localparam logic [IW-1:0] CLASS_INDEX  = cfg_header_pkg::CLASS_OFFSET[7:2];
  localparam logic [IW-1:0] TENURE_INDEX = cfg_header_pkg::TENURE_OFFSET[7:2];
  localparam logic [IW-1:0] WINDOW_INDEX = cfg_header_pkg::WINDOW_OFFSET[7:2];

  // Merge write data into a stored word lane by lane
  function automatic logic [31:0] merge_bytes(
    input logic [31:0] old_value,
    input logic [31:0] new_value,
    input logic [3:0]  byte_enable
  );
    logic [31:0] result;
    result = old_value;
    for (int lane = 0; lane < 4; lane++) begin
      if (byte_enable[lane]) begin
        result[lane*8 +: 8] = new_value[lane*8 +: 8];
      end
    end
    return result;
  endfunction

  // Whether an initiator command moves whole cache lines
  function automatic logic uses_line(input logic [3:0] command);
    return (command == cfg_header_pkg::CMD_READ_MULTIPLE)
        || (command == cfg_header_pkg::CMD_READ_LINE)
        || (command == cfg_header_pkg::CMD_WRITE_INVALIDATE);
  endfunction

  cfg_header_pkg::cfg_req_type      req;
  cfg_header_pkg::header_state_type state_reg;
  cfg_header_pkg::header_state_type state_next;

  logic [31:0] class_word;
  logic [31:0] tenure_word;
  logic [31:0] window_word;
  logic [31:0] merged_tenure;
  logic [31:0] merged_window;

  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic        ack_reg;
  logic        ack_next;

  logic        claim_reg;
  logic        claim_next;
  logic        window_hit;

  logic        expired;
  logic        expired_reg;
  logic        terminate_reg;
  logic        terminate_next;
  logic [7:0]  line_reg;
  logic [7:0]  burst_reg;
  logic [7:0]  burst_next;

  assign req.write       = CFG_WRITE;
  assign req.index       = CFG_INDEX;
  assign req.byte_enable = CFG_BE;
  assign req.wdata       = CFG_WDATA;

  // Read views of the three configuration words
  assign class_word = {cfg_header_pkg::BASE_CATEGORY_VALUE,
                       cfg_header_pkg::SUBCLASS_VALUE,
                       cfg_header_pkg::PROGRAMMING_MODEL,
                       SILICON_REVISION};

  assign tenure_word = {cfg_header_pkg::SELF_TEST_VALUE,
                        cfg_header_pkg::LAYOUT_KIND_VALUE,
                        state_reg.tenure_limit,
                        state_reg.line_size_setting};

  assign window_word = {state_reg.window_base_pointer,
                        cfg_header_pkg::WINDOW_SIZE_CODE,
                        cfg_header_pkg::PREFETCH_FLAG,
                        cfg_header_pkg::DECODE_WIDTH_TYPE,
                        cfg_header_pkg::SPACE_INDICATOR};

  // Lanes 3 and 2 of the tenure word are fixed, so they never take data
  assign merged_tenure = merge_bytes(tenure_word, req.wdata,
                                     {2'b00, req.byte_enable[1:0]});

  // Low bits of the window word are masked off after the merge
  assign merged_window = merge_bytes(window_word, req.wdata, req.byte_enable)
                       & cfg_header_pkg::WINDOW_WRITE_MASK;

  // Configuration register state
  always_comb begin
    state_next = state_reg;
    if (CFG_SEL && req.write) begin
      if (req.index == TENURE_INDEX) begin
        state_next.tenure_limit      = merged_tenure[15:8];
        state_next.line_size_setting = merged_tenure[7:0];
      end
      if (req.index == WINDOW_INDEX) begin
        state_next.window_base_pointer =
          merged_window[31:cfg_header_pkg::WINDOW_LSB];
      end
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      state_reg.tenure_limit        <= cfg_header_pkg::TENURE_LIMIT_RESET;
      state_reg.line_size_setting   <= cfg_header_pkg::LINE_SIZE_RESET;
      state_reg.window_base_pointer <= cfg_header_pkg::WINDOW_BASE_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // Configuration answer: one cycle after the access, reads give the old value
  always_comb begin
    ack_next   = CFG_SEL;
    rdata_next = 32'h00000000;
    if (CFG_SEL && !req.write) begin
      unique case (req.index)
        CLASS_INDEX:  rdata_next = class_word;
        TENURE_INDEX: rdata_next = tenure_word;
        WINDOW_INDEX: rdata_next = window_word;
        default:      rdata_next = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      ack_reg   <= 1'b0;
      rdata_reg <= 32'h00000000;
    end else begin
      ack_reg   <= ack_next;
      rdata_reg <= rdata_next;
    end
  end

  // Memory window decode
  window_match u_window (
    .enable       (MEMORY_RESPONSE_ENABLE),
    .base_pointer (state_reg.window_base_pointer),
    .cycle        (MEM_CYCLE),
    .address      (MEM_ADDR),
    .hit          (window_hit)
  );

  always_comb begin
    claim_next = window_hit;
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      claim_reg <= 1'b0;
    end else begin
      claim_reg <= claim_next;
    end
  end

  // Initiator tenure tracking
  tenure_timer u_tenure (
    .clk     (CLK),
    .resetn  (RESETN),
    .start   (FRAME_START),
    .busy    (TRANSFER_BUSY),
    .limit   (state_reg.tenure_limit),
    .expired (expired)
  );

  // Grant is sampled as a plain level; a grant still held lets the burst run on
  always_comb begin
    terminate_next = expired && TRANSFER_BUSY && !FRAME_START && GNT_N;
    // A zero line size would stall a line command, so it falls back to one word
    if (uses_line(INIT_CMD) && (state_reg.line_size_setting != 8'h00)) begin
      burst_next = state_reg.line_size_setting;
    end else begin
      burst_next = 8'h01;
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      expired_reg   <= 1'b0;
      terminate_reg <= 1'b0;
      line_reg      <= cfg_header_pkg::LINE_SIZE_RESET;
      burst_reg     <= 8'h01;
    end else begin
      expired_reg   <= expired;
      terminate_reg <= terminate_next;
      line_reg      <= state_reg.line_size_setting;
      burst_reg     <= burst_next;
    end
  end

  // Port drive
  assign CFG_RDATA      = rdata_reg;
  assign CFG_ACK        = ack_reg;
  assign MEM_CLAIM      = claim_reg;
  assign TENURE_EXPIRED = expired_reg;
  assign TERMINATE_REQ  = terminate_reg;
  assign LINE_SIZE      = line_reg;
  assign BURST_WORDS    = burst_reg;

endmodule
`default_nettype wire

/* File: dv/cfg_header_regs_sva.sv */
// Port assertions for the configuration header block
`timescale 1ns/1ps
`default_nettype none
module cfg_header_sva #(
  // Value is arbitrary
  parameter logic [7:0] SILICON_REVISION = 8'h5a
) (
  // Clock and reset
  input wire logic        CLK,
  input wire logic        RESETN,
  // Configuration access
  input wire logic        CFG_SEL,
  input wire logic        CFG_WRITE,
  input wire logic [5:0]  CFG_INDEX,
  input wire logic [3:0]  CFG_BE,
  input wire logic [31:0] CFG_WDATA,
  input wire logic [31:0] CFG_RDATA,
  // Window and initiator
  input wire logic        MEMORY_RESPONSE_ENABLE,
  input wire logic        MEM_CYCLE,
  input wire logic        MEM_CLAIM,
  input wire logic        FRAME_START,
  input wire logic        TRANSFER_BUSY,
  input wire logic        GNT_N,
  input wire logic [3:0]  INIT_CMD,
  input wire logic        TERMINATE_REQ,
  input wire logic [7:0]  LINE_SIZE,
  input wire logic [7:0]  BURST_WORDS
);
  default clocking dcb @(posedge CLK); endclocking
  default disable iff (!RESETN);
  wire logic rd = CFG_SEL && !CFG_WRITE;
  wire logic wl = CFG_SEL && CFG_WRITE && CFG_INDEX == 6'h03 && CFG_BE[0];
  wire logic mq = MEM_CYCLE && MEMORY_RESPONSE_ENABLE;
  wire logic tq = GNT_N && TRANSFER_BUSY && !FRAME_START;
  wire logic ones = CFG_SEL && CFG_WRITE && CFG_INDEX == 6'h04 && CFG_BE == 4'hf
                    && CFG_WDATA == 32'hffffffff;

  AST_CLASS: assert property (rd && CFG_INDEX == 6'h02 |=>
    CFG_RDATA == {8'h0c, 8'h00, 8'h10, SILICON_REVISION}) else $error("class word wrong");
  AST_LAYOUT: assert property (rd && CFG_INDEX == 6'h03 |=>
    CFG_RDATA[31:16] == 16'h0000) else $error("layout half word wrong");
  AST_LOWBITS: assert property (rd && CFG_INDEX == 6'h04 |=>
    CFG_RDATA[10:0] == 11'h000) else $error("window low bits not zero");
  AST_SIZE: assert property (ones ##1 (rd && CFG_INDEX == 6'h04) |=>
    CFG_RDATA == 32'hfffff800) else $error("size mask wrong");
  AST_LINE: assert property (wl ##1 !wl |=>
    LINE_SIZE == $past(CFG_WDATA[7:0], 2)) else $error("line size not stored");
  AST_BURST: assert property ((INIT_CMD == 4'he && LINE_SIZE != 8'h00)
    ##1 $stable(LINE_SIZE) |-> BURST_WORDS == LINE_SIZE) else $error("burst not line size");
  AST_SINGLE: assert property (!(INIT_CMD inside {4'hc, 4'he, 4'hf}) |=>
    BURST_WORDS == 8'h01) else $error("burst not single");
  AST_CLAIM: assert property (MEM_CLAIM |-> $past(mq))
    else $error("claim without enabled cycle");
  AST_TERM: assert property (TERMINATE_REQ |-> $past(tq))
    else $error("terminate while granted or idle");

  cover property (ones ##1 rd);
  cover property (MEM_CLAIM);
  cover property ($rose(TERMINATE_REQ));
endmodule
bind cfg_header_regs cfg_header_sva #(.SILICON_REVISION(SILICON_REVISION)) u_sva (.CLK, .RESETN,
  .CFG_SEL, .CFG_WRITE, .CFG_INDEX, .CFG_BE, .CFG_WDATA, .CFG_RDATA, .MEMORY_RESPONSE_ENABLE,
  .MEM_CYCLE, .MEM_CLAIM, .FRAME_START, .TRANSFER_BUSY, .GNT_N, .INIT_CMD, .TERMINATE_REQ,
  .LINE_SIZE, .BURST_WORDS);
`default_nettype wire

/* File: dv/cfg_host_model.sv */
// Configuration software model that issues dword accesses
`timescale 1ns/1ps
`default_nettype none
module cfg_host_model (
  // Clock
  input  wire logic        clk,
  // Access toward the device
  output var logic         sel,
  output var logic         write,
  output var logic [5:0]   index,
  output var logic [3:0]   be,
  output var logic [31:0]  wdata
);
  initial begin
    {sel, write, index, be, wdata} = '0;
  end

  // One access per call; calls may follow each other with no gap
  task automatic issue(input logic go, input cfg_header_pkg::cfg_req_type r);
    @(posedge clk);
    sel   <= go;
    write <= r.write;
    index <= r.index;
    be    <= r.byte_enable;
    // Released data lines are scrambled so nothing leans on a stale value
    wdata <= go ? r.wdata : ~wdata;
  endtask
endmodule
`default_nettype wire

/* File: dv/tb_top.sv */
// Self-checking bench for the configuration header block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  typedef struct packed {
    cfg_header_pkg::cfg_req_type req;
    logic [31:0]                 exp;
  } row_type;
  logic        CLK = 1'b0, RESETN = 1'b0;
  logic        CFG_SEL, CFG_WRITE, CFG_ACK, MEM_CLAIM, TENURE_EXPIRED, TERMINATE_REQ;
  logic        MEMORY_RESPONSE_ENABLE = 1'b0, MEM_CYCLE = 1'b0, FRAME_START = 1'b0;
  logic        TRANSFER_BUSY = 1'b0, GNT_N = 1'b1;
  logic [5:0]  CFG_INDEX;
  logic [3:0]  CFG_BE, INIT_CMD = 4'h0;
  logic [31:0] CFG_WDATA, CFG_RDATA, MEM_ADDR = 32'h0;
  logic [7:0]  LINE_SIZE, BURST_WORDS;
  logic [3:0]  cmds [4] = '{4'hc, 4'he, 4'hf, 4'h7};
  row_type     rows [14];
  int          fails = 0, compares = 0, cycles = 0;

  cfg_header_regs #(.SILICON_REVISION(8'h3c)) DUT (.CLK, .RESETN, .CFG_SEL, .CFG_WRITE,
    .CFG_INDEX, .CFG_BE, .CFG_WDATA, .CFG_RDATA, .CFG_ACK, .MEMORY_RESPONSE_ENABLE, .MEM_CYCLE,
    .MEM_ADDR, .MEM_CLAIM, .FRAME_START, .TRANSFER_BUSY, .GNT_N, .INIT_CMD, .TENURE_EXPIRED,
    .TERMINATE_REQ, .LINE_SIZE, .BURST_WORDS);
  cfg_host_model host (.clk(CLK), .sel(CFG_SEL), .write(CFG_WRITE), .index(CFG_INDEX),
    .be(CFG_BE), .wdata(CFG_WDATA));

  always #10 CLK = ~CLK;
  always @(posedge CLK) begin
    cycles++;
    if (cycles == 2000) begin
      fails++;
      wrap_up();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic mem(input logic en, input logic [31:0] a, input logic exp);
    @(posedge CLK);
    MEMORY_RESPONSE_ENABLE <= en;
    MEM_CYCLE <= 1'b1;
    MEM_ADDR <= a;
    @(posedge CLK);
    MEM_CYCLE <= 1'b0;
    MEM_ADDR <= ~a;
    #1;
    chk(MEM_CLAIM, exp);
  endtask

  task automatic wrap_up();
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    rows[0]  = '{'{1'b0, 6'h03, 4'hf, 32'h0}, 32'h0};
    rows[1]  = '{'{1'b0, 6'h04, 4'hf, 32'h0}, 32'h0};
    rows[2]  = '{'{1'b0, 6'h02, 4'hf, 32'h0}, 32'h0c00103c};
    rows[3]  = '{'{1'b1, 6'h02, 4'hf, 32'hffffffff}, 32'h0};
    rows[4]  = '{'{1'b0, 6'h02, 4'hf, 32'h0}, 32'h0c00103c};
    rows[5]  = '{'{1'b1, 6'h03, 4'hf, 32'hffff0310}, 32'h0};
    rows[6]  = '{'{1'b0, 6'h03, 4'hf, 32'h0}, 32'h00000310};
    rows[7]  = '{'{1'b1, 6'h04, 4'hf, 32'hffffffff}, 32'h0};
    rows[8]  = '{'{1'b0, 6'h04, 4'hf, 32'h0}, 32'hfffff800};
    rows[9]  = '{'{1'b1, 6'h04, 4'hf, 32'h12345fff}, 32'h0};
    rows[10] = '{'{1'b0, 6'h04, 4'hf, 32'h0}, 32'h12345800};
    rows[11] = '{'{1'b1, 6'h04, 4'h2, 32'h0}, 32'h0};
    rows[12] = '{'{1'b0, 6'h04, 4'hf, 32'h0}, 32'h12340000};
    rows[13] = '{'{1'b0, 6'h3f, 4'hf, 32'h0}, 32'h0};
    repeat (5) @(posedge CLK);
    RESETN <= 1'b1;
    // Back to back: each row's answer is checked while the next row is on the bus
    for (int i = 0; i <= 14; i++) begin
      host.issue(i < 14, rows[i % 14].req);
      #1;
      if (i > 0) begin
        chk(CFG_ACK, 1'b1);
        chk(CFG_RDATA, rows[i - 1].exp);
      end
    end
    foreach (cmds[k]) begin
      @(posedge CLK);
      INIT_CMD <= cmds[k];
      @(posedge CLK);
      #1;
      chk(BURST_WORDS, k < 3 ? 32'h10 : 32'h01);
    end
    mem(1'b1, 32'h123407fc, 1'b1);
    mem(1'b1, 32'h12340800, 1'b0);
    mem(1'b0, 32'h12340000, 1'b0);
    @(posedge CLK);
    FRAME_START <= 1'b1;
    TRANSFER_BUSY <= 1'b1;
    @(posedge CLK);
    FRAME_START <= 1'b0;
    repeat (3) @(posedge CLK);
    #1;
    chk(TENURE_EXPIRED, 1'b0);
    @(posedge CLK);
    #1;
    chk(TENURE_EXPIRED, 1'b1);
    chk(TERMINATE_REQ, 1'b1);
    @(posedge CLK);
    GNT_N <= 1'b0;
    @(posedge CLK);
    #1;
    chk(TERMINATE_REQ, 1'b0);
    @(posedge CLK);
    FRAME_START <= 1'b1;
    @(posedge CLK);
    FRAME_START <= 1'b0;
    @(posedge CLK);
    #1;
    chk(TENURE_EXPIRED, 1'b0);
    @(posedge CLK);
    RESETN <= 1'b0;
    TRANSFER_BUSY <= 1'b0;
    repeat (5) @(posedge CLK);
    RESETN <= 1'b1;
    // A line command with the reset line size of zero must fall back to one word
    INIT_CMD <= 4'hf;
    host.issue(1'b1, rows[0].req);
    #1;
    chk(LINE_SIZE, 32'h00);
    host.issue(1'b1, rows[1].req);
    #1;
    chk(CFG_RDATA, 32'h0);
    chk(BURST_WORDS, 32'h01);
    host.issue(1'b0, rows[1].req);
    #1;
    chk(CFG_RDATA, 32'h0);
    wrap_up();
  end
endmodule
`default_nettype wire
